/* shared/flash_cmd_pkg.sv */
// Opcodes, address masks, counts and state types of the flash command sequencer
package flash_cmd_pkg;

   localparam logic [7:0] OP_WRITE_UNLOCK_CMD = 8'h06;
   localparam logic [7:0] OP_FOUR_LANE_PAGE_LOAD = 8'h32;
   localparam logic [7:0] OP_FOUR_LANE_LOAD_WIDE_ADDR = 8'h34;
   localparam logic [7:0] OP_SMALL_UNIT_WIPE = 8'h20;
   localparam logic [7:0] OP_SMALL_UNIT_WIPE_WIDE_ADDR = 8'h21;
   localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
   localparam logic [7:0] OP_HALF_BLOCK_WIPE_WIDE_ADDR = 8'h53;
   localparam logic [7:0] OP_FULL_BLOCK_WIPE = 8'hd8;
   localparam logic [7:0] OP_FULL_BLOCK_WIPE_WIDE_ADDR = 8'hdc;
   localparam logic [7:0] OP_ARRAY_WIPE_A = 8'h60;
   localparam logic [7:0] OP_ARRAY_WIPE_B = 8'hc7;

   localparam logic [5:0] BITS_OPC = 6'h08;
   localparam logic [5:0] BITS_ADDR3 = 6'h18;
   localparam logic [5:0] BITS_ADDR4 = 6'h20;
   localparam logic [5:0] LANE_1 = 6'h01;
   localparam logic [5:0] LANE_4 = 6'h04;

   localparam logic [31:0] MASK_BYTE = 32'hffff_ffff;
   localparam logic [31:0] MASK_UNIT = 32'hffff_f000;
   localparam logic [31:0] MASK_HALF = 32'hffff_8000;
   localparam logic [31:0] MASK_BLOCK = 32'hffff_0000;
   localparam logic [31:0] MASK_ARRAY = 32'h0000_0000;

   localparam logic [8:0] PAGE_BYTES = 9'h100;
   localparam logic [2:0] LAST_BYTE = 3'h7;
   localparam int WORD_W = 64;
   localparam int FIFO_DEPTH = 32;

   typedef enum logic [2:0] {
      ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_END, ST_SKIP, ST_CHECK
   } seq_st_t;

   typedef enum logic [2:0] {
      K_NONE, K_LOAD, K_UNIT, K_HALF, K_BLOCK, K_ARRAY
   } op_kind_t;

endpackage : flash_cmd_pkg

/* verilog/pin_sync.sv */
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_s_t;

   sync_s_t r;
   sync_s_t n;

   // First stage feeds only the second
   always_comb begin
      n.s1 = d;
      n.s2 = r.s1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign q = r.s2;

endmodule : pin_sync

`default_nettype wire

/* verilog/page_fifo.sv */
// Page buffer FIFO with registered read stage and drain gate
`timescale 1ns/10ps
`default_nettype none

module page_fifo #(
   parameter int W = 64,
   parameter int D = 32
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   input wire logic out_en,
   input wire logic out_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   output logic empty
);

   localparam int AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);
   localparam logic [AW-1:0] LAST = (AW)'(D - 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic [W-1:0] q;
      logic qv;
   } fifo_s_t;

   fifo_s_t r;
   fifo_s_t n;

   assign in_ready = (r.cnt != FULL);
   assign out_valid = r.qv;
   assign out_data = r.q;
   assign empty = (r.cnt == '0) && !r.qv;

   // Pointers wrap by hand so a depth off a power of two still works
   always_comb begin
      n = r;
      if (out_ready) begin
         n.qv = 1'b0;
      end
      if (in_valid && in_ready) begin
         n.mem[r.wp] = in_data;
         n.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
         n.cnt = n.cnt + 1'b1;
      end
      // Read stage only loads while the owner lets it drain
      if (out_en && !n.qv && r.cnt != '0) begin
         n.q = r.mem[r.rp];
         n.qv = 1'b1;
         n.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
         n.cnt = n.cnt - 1'b1;
      end
      if (flush) begin
         n.wp = '0;
         n.rp = '0;
         n.cnt = '0;
         n.qv = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

endmodule : page_fifo

`default_nettype wire

/* verilog/flash_seq.sv */
// Four-lane page load and array wipe command sequencer of the serial flash
`timescale 1ns/10ps
`default_nettype none

module flash_seq #(
   parameter logic [23:0] PROG_CYC = 24'h000100,
   parameter logic [23:0] ERASE_CYC = 24'h000400,
   parameter logic [23:0] CHIP_CYC = 24'h001000
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] io_in,
   input wire logic quad_en,
   input wire logic four_lane_cmd_mode,
   input wire logic addr_len_sel,
   input wire logic chk_prot,
   input wire logic err_clr,
   input wire logic prog_ready,
   output logic op_in_progress,
   output logic write_latch,
   output logic erase_err,
   output logic prog_err,
   output logic chk_req,
   output logic array_go,
   output flash_cmd_pkg::op_kind_t array_kind,
   output logic [31:0] array_addr,
   output logic [8:0] array_len,
   output logic prog_valid,
   output logic [63:0] prog_data
);

   ////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      flash_cmd_pkg::seq_st_t st;
      flash_cmd_pkg::op_kind_t kind;
      logic sck_d;
      logic cs_d;
      logic [5:0] cnt;
      logic [7:0] opc;
      logic [31:0] addr;
      logic wide;
      logic ph;
      logic [3:0] hi;
      logic [8:0] len;
      logic [2:0] bidx;
      logic [63:0] word;
      logic wl;
      logic run;
      logic drain;
      logic go;
      logic chk;
      logic eerr;
      logic perr;
      logic [23:0] tmr;
   } seq_s_t;

   seq_s_t r;
   seq_s_t n;

   logic [5:0] pins;
   logic s_sck;
   logic s_act;
   logic [3:0] s_io;
   logic sck_rise;
   logic sel_on;
   logic sel_off;
   logic ql;
   logic [5:0] lanes;
   logic [5:0] ncnt;
   logic [7:0] nop;
   logic [7:0] byte_in;
   logic [31:0] amask;
   logic [23:0] tload;
   logic push;
   logic flush;
   logic [63:0] push_word;
   logic fifo_ready;
   logic fifo_empty;

   ////////////////////////////////////////////////////////////////////////
   // Pin capture

   // Select inverted ahead of the first stage so reset reads as idle
   pin_sync #(
      .W(6)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d({sck, ~cs_n, io_in}),
      .q(pins)
   );

   assign s_sck = pins[5];
   assign s_act = pins[4];
   assign s_io = pins[3:0];

   // Edges from the synchronised copies only
   assign sck_rise = s_sck && !r.sck_d;
   assign sel_on = s_act && !r.cs_d;
   assign sel_off = !s_act && r.cs_d;

   ////////////////////////////////////////////////////////////////////////
   // Page buffer

   page_fifo #(
      .W(flash_cmd_pkg::WORD_W),
      .D(flash_cmd_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .flush(flush),
      .in_valid(push),
      .in_data(push_word),
      .in_ready(fifo_ready),
      .out_en(r.drain),
      .out_ready(prog_ready),
      .out_valid(prog_valid),
      .out_data(prog_data),
      .empty(fifo_empty)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      n = r;
      push = 1'b0;
      flush = 1'b0;
      push_word = r.word;
      ql = four_lane_cmd_mode;
      lanes = ql ? flash_cmd_pkg::LANE_4 : flash_cmd_pkg::LANE_1;
      ncnt = r.cnt + lanes;
      nop = ql ? {r.opc[3:0], s_io} : {r.opc[6:0], s_io[0]};
      byte_in = {r.hi, s_io};
      case (r.kind)
         flash_cmd_pkg::K_UNIT: amask = flash_cmd_pkg::MASK_UNIT;
         flash_cmd_pkg::K_HALF: amask = flash_cmd_pkg::MASK_HALF;
         flash_cmd_pkg::K_BLOCK: amask = flash_cmd_pkg::MASK_BLOCK;
         flash_cmd_pkg::K_ARRAY: amask = flash_cmd_pkg::MASK_ARRAY;
         default: amask = flash_cmd_pkg::MASK_BYTE;
      endcase
      case (r.kind)
         flash_cmd_pkg::K_LOAD: tload = PROG_CYC;
         flash_cmd_pkg::K_ARRAY: tload = CHIP_CYC;
         default: tload = ERASE_CYC;
      endcase
      n.sck_d = s_sck;
      n.cs_d = s_act;
      n.go = 1'b0;
      n.chk = 1'b0;

      // Clear first, so a set in this cycle still lands
      if (err_clr) begin
         n.eerr = 1'b0;
         n.perr = 1'b0;
      end

      if (r.run) begin
         if (r.tmr != '0) begin
            n.tmr = r.tmr - 24'h000001;
         end else if (!r.drain || fifo_empty) begin
            n.run = 1'b0;
            n.drain = 1'b0;
            n.wl = 1'b0;
         end
      end

      // One-cycle protection query, answered by array logic
      if (r.st == flash_cmd_pkg::ST_CHECK) begin
         n.st = flash_cmd_pkg::ST_IDLE;
         if (chk_prot) begin
            n.wl = 1'b0;
            if (r.kind == flash_cmd_pkg::K_LOAD) begin
               n.perr = 1'b1;
               flush = 1'b1;
            end else begin
               n.eerr = 1'b1;
            end
         end else begin
            n.run = 1'b1;
            n.go = 1'b1;
            n.tmr = tload;
            n.drain = (r.kind == flash_cmd_pkg::K_LOAD);
         end
      end else if (sel_off) begin
         n.st = flash_cmd_pkg::ST_IDLE;
         if (r.st == flash_cmd_pkg::ST_END) begin
            if (r.kind == flash_cmd_pkg::K_NONE) begin
               n.wl = 1'b1;
            end else begin
               n.st = flash_cmd_pkg::ST_CHECK;
               n.chk = 1'b1;
               n.addr = r.addr & amask;
            end
         end else if (r.st == flash_cmd_pkg::ST_DATA) begin
            if (!r.ph && r.len != '0) begin
               n.st = flash_cmd_pkg::ST_CHECK;
               n.chk = 1'b1;
               push = (r.bidx != '0);
            end else begin
               flush = 1'b1;
            end
         end
      end else if (sel_on) begin
         n.st = flash_cmd_pkg::ST_OPC;
         n.kind = flash_cmd_pkg::K_NONE;
         n.cnt = '0;
         n.addr = '0;
         n.len = '0;
         n.bidx = '0;
         n.ph = 1'b0;
         n.word = '1;
      end else if (sck_rise && s_act) begin
         case (r.st)
            flash_cmd_pkg::ST_OPC: begin
               n.opc = nop;
               n.cnt = ncnt;
               if (ncnt == flash_cmd_pkg::BITS_OPC) begin
                  n.cnt = '0;
                  n.wide = addr_len_sel || nop inside {
                     flash_cmd_pkg::OP_FOUR_LANE_LOAD_WIDE_ADDR,
                     flash_cmd_pkg::OP_SMALL_UNIT_WIPE_WIDE_ADDR,
                     flash_cmd_pkg::OP_HALF_BLOCK_WIPE_WIDE_ADDR,
                     flash_cmd_pkg::OP_FULL_BLOCK_WIPE_WIDE_ADDR};
                  case (nop)
                     flash_cmd_pkg::OP_FOUR_LANE_PAGE_LOAD,
                     flash_cmd_pkg::OP_FOUR_LANE_LOAD_WIDE_ADDR: begin
                        n.kind = flash_cmd_pkg::K_LOAD;
                     end
                     flash_cmd_pkg::OP_SMALL_UNIT_WIPE,
                     flash_cmd_pkg::OP_SMALL_UNIT_WIPE_WIDE_ADDR: begin
                        n.kind = flash_cmd_pkg::K_UNIT;
                     end
                     flash_cmd_pkg::OP_HALF_BLOCK_WIPE,
                     flash_cmd_pkg::OP_HALF_BLOCK_WIPE_WIDE_ADDR: begin
                        n.kind = flash_cmd_pkg::K_HALF;
                     end
                     flash_cmd_pkg::OP_FULL_BLOCK_WIPE,
                     flash_cmd_pkg::OP_FULL_BLOCK_WIPE_WIDE_ADDR: begin
                        n.kind = flash_cmd_pkg::K_BLOCK;
                     end
                     flash_cmd_pkg::OP_ARRAY_WIPE_A,
                     flash_cmd_pkg::OP_ARRAY_WIPE_B: begin
                        n.kind = flash_cmd_pkg::K_ARRAY;
                     end
                     default: begin
                        n.kind = flash_cmd_pkg::K_NONE;
                     end
                  endcase
                  n.st = flash_cmd_pkg::ST_SKIP;
                  if (!r.run && r.wl && n.kind != flash_cmd_pkg::K_NONE) begin
                     n.st = (n.kind == flash_cmd_pkg::K_ARRAY) ?
                        flash_cmd_pkg::ST_END : flash_cmd_pkg::ST_ADDR;
                  end
                  if (n.kind == flash_cmd_pkg::K_LOAD && !quad_en) begin
                     n.st = flash_cmd_pkg::ST_SKIP;
                  end
                  if (!r.run && nop == flash_cmd_pkg::OP_WRITE_UNLOCK_CMD) begin
                     n.st = flash_cmd_pkg::ST_END;
                  end
               end
            end
            flash_cmd_pkg::ST_ADDR: begin
               n.addr = ql ? {r.addr[27:0], s_io} : {r.addr[30:0], s_io[0]};
               n.cnt = ncnt;
               if (ncnt == (r.wide ? flash_cmd_pkg::BITS_ADDR4
                                   : flash_cmd_pkg::BITS_ADDR3)) begin
                  n.cnt = '0;
                  n.st = (r.kind == flash_cmd_pkg::K_LOAD) ?
                     flash_cmd_pkg::ST_DATA : flash_cmd_pkg::ST_END;
               end
            end
            flash_cmd_pkg::ST_DATA: begin
               // four bits a clock, one page
               n.ph = !r.ph;
               n.hi = s_io;
               if (r.ph && r.len < flash_cmd_pkg::PAGE_BYTES && fifo_ready) begin
                  n.len = r.len + 9'h001;
                  n.bidx = r.bidx + 3'h1;
                  n.word[r.bidx*8 +: 8] = byte_in;
                  if (r.bidx == flash_cmd_pkg::LAST_BYTE) begin
                     push = 1'b1;
                     push_word = n.word;
                     n.word = '1;
                  end
               end
            end
            flash_cmd_pkg::ST_END: begin
               n.st = flash_cmd_pkg::ST_SKIP;
            end
            default: begin
               n.st = r.st;
            end
         endcase
      end
   end

   // Single register bank for the whole sequencer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign op_in_progress = r.run;
   assign write_latch = r.wl;
   assign erase_err = r.eerr;
   assign prog_err = r.perr;
   assign chk_req = r.chk;
   assign array_go = r.go;
   assign array_kind = r.kind;
   assign array_addr = r.addr;
   assign array_len = r.len;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   property p_go_busy;
      array_go |-> op_in_progress && !$past(op_in_progress);
   endproperty
   a_go_busy: assert property (p_go_busy) else $error("start without busy rise");

   property p_go_latch;
      array_go |-> $past(write_latch, 2) && $past(chk_req);
   endproperty
   a_go_latch: assert property (p_go_latch) else $error("start without latch");

   property p_end_latch;
      $fell(op_in_progress) |-> !write_latch && !prog_valid;
   endproperty
   a_end_latch: assert property (p_end_latch) else $error("latch kept after end");

   property p_eerr;
      chk_req && chk_prot && array_kind != flash_cmd_pkg::K_LOAD
         |=> erase_err && !op_in_progress && !array_go;
   endproperty
   a_eerr: assert property (p_eerr) else $error("protected wipe ran");

   property p_perr;
      chk_req && chk_prot && array_kind == flash_cmd_pkg::K_LOAD |=> prog_err && !array_go;
   endproperty
   a_perr: assert property (p_perr) else $error("protected load ran");

   property p_half;
      array_go && array_kind == flash_cmd_pkg::K_HALF
         |-> (array_addr & ~flash_cmd_pkg::MASK_HALF) == '0;
   endproperty
   a_half: assert property (p_half) else $error("half block misaligned");

   property p_page;
      array_len <= flash_cmd_pkg::PAGE_BYTES;
   endproperty
   a_page: assert property (p_page) else $error("page overrun");

   property p_sticky;
      erase_err && !err_clr |=> erase_err;
   endproperty
   a_sticky: assert property (p_sticky) else $error("erase error lost");

   property p_late_clk;
      r.st == flash_cmd_pkg::ST_END && sck_rise && s_act |=> r.st == flash_cmd_pkg::ST_SKIP;
   endproperty
   a_late_clk: assert property (p_late_clk) else $error("late clock kept command");

   property p_load_gate;
      r.st == flash_cmd_pkg::ST_DATA |-> write_latch && quad_en;
   endproperty
   a_load_gate: assert property (p_load_gate) else $error("load without enable");

endmodule : flash_seq

`default_nettype wire

/* verification/spi_host_model.sv */
// Serial host model framing commands on select, clock and four lanes
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
   input wire logic sys_clk,
   output logic sck,
   output logic cs_n,
   output logic [3:0] io_in
);
   // Idle link: clock parked low, select high
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      io_in = 4'h0;
   end

   // slow serial clock, 200 ns period
   task automatic half_clk();
      repeat (4) @(posedge sys_clk);
   endtask : half_clk

   task automatic shift(input logic [31:0] v, input int nbits, input int lanes);
      int i;
      for (i = nbits; i > 0; i -= lanes) begin
         if (lanes == 4) begin
            io_in <= v[i-1 -: 4];
         end else begin
            io_in <= {~io_in[3:1], v[i-1]};
         end
         half_clk();
         sck <= 1'b1;
         half_clk();
         sck <= 1'b0;
      end
   endtask : shift

   // select rises half a serial clock (4 sys_clk cycles) after the last unit
   task automatic frame(input logic [7:0] op, input int ol, input logic [31:0] a,
                        input int ab, input int nb, input int extra);
      int k;
      cs_n <= 1'b0;
      half_clk();
      shift({24'h0, op}, 8, ol);
      shift(a, ab, ol);
      // data bytes carry their index, targets assumed erased
      for (k = 0; k < nb; k++) begin
         shift({24'h0, k[7:0]}, 8, 4);
      end
      shift(32'h0, extra, 1);
      half_clk();
      cs_n <= 1'b1;
      // Released lanes float, so show the inverse of the last level
      io_in <= ~io_in;
      repeat (8) @(posedge sys_clk);
   endtask : frame
endmodule : spi_host_model
`default_nettype wire

/* verification/flash_quad_program_and_erase_cmds_tb.sv */
// Self-checking bench of the flash command sequencer
`timescale 1ns/10ps
`default_nettype none

module flash_quad_program_and_erase_cmds_tb;
   localparam logic [23:0] PROG_N = 24'h000010;
   localparam logic [23:0] ERASE_N = 24'h000020;
   localparam logic [23:0] CHIP_N = 24'h000040;
   typedef struct {
      logic [7:0] op;
      logic ql;
      logic al;
      int ab;
      logic [31:0] a;
      logic prot;
      flash_cmd_pkg::op_kind_t kind;
      logic [31:0] ea;
   } row_t;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic sck, cs_n, quad_en, four_lane_cmd_mode, addr_len_sel, chk_prot, err_clr, prog_ready;
   logic [3:0] io_in;
   logic op_in_progress, write_latch, erase_err, prog_err, chk_req, array_go, prog_valid;
   flash_cmd_pkg::op_kind_t array_kind, cap_kind;
   logic [31:0] array_addr, cap_addr;
   logic [8:0] array_len, cap_len;
   logic [63:0] prog_data;
   logic [63:0] words[$];
   int cyc, n_chk, n_go, n_busy, b_chk, b_go, b_busy, err_total, total_checks;
   row_t rows [12] = '{
      '{8'h20, 0, 1, 32, 32'h89abcdef, 0, flash_cmd_pkg::K_UNIT, 32'h89abc000},
      '{8'h21, 1, 0, 32, 32'h00001fff, 0, flash_cmd_pkg::K_UNIT, 32'h00001000},
      '{8'h52, 0, 0, 24, 32'h00ab7fff, 0, flash_cmd_pkg::K_HALF, 32'h00ab0000},
      '{8'h52, 1, 0, 24, 32'h00ab8001, 0, flash_cmd_pkg::K_HALF, 32'h00ab8000},
      '{8'h53, 0, 0, 32, 32'h1234f000, 0, flash_cmd_pkg::K_HALF, 32'h12348000},
      '{8'hd8, 0, 0, 24, 32'h0033ffff, 0, flash_cmd_pkg::K_BLOCK, 32'h00330000},
      '{8'hdc, 1, 1, 32, 32'hffff1234, 0, flash_cmd_pkg::K_BLOCK, 32'hffff0000},
      '{8'h60, 0, 0, 0, 32'h0, 0, flash_cmd_pkg::K_ARRAY, 32'h0},
      '{8'hc7, 1, 0, 0, 32'h0, 0, flash_cmd_pkg::K_ARRAY, 32'h0},
      '{8'h20, 0, 0, 24, 32'h00000010, 1, flash_cmd_pkg::K_UNIT, 32'h0},
      '{8'h53, 1, 0, 32, 32'h00018000, 1, flash_cmd_pkg::K_HALF, 32'h00018000},
      '{8'hc7, 0, 0, 0, 32'h0, 1, flash_cmd_pkg::K_ARRAY, 32'h0}
   };

   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   flash_seq #(.PROG_CYC(PROG_N), .ERASE_CYC(ERASE_N), .CHIP_CYC(CHIP_N)) dut_u (
      .sys_clk, .rst, .sck, .cs_n, .io_in, .quad_en, .four_lane_cmd_mode, .addr_len_sel,
      .chk_prot, .err_clr, .prog_ready, .op_in_progress, .write_latch, .erase_err,
      .prog_err, .chk_req, .array_go, .array_kind, .array_addr, .array_len, .prog_valid,
      .prog_data
   );

   spi_host_model host_u (.sys_clk, .sck, .cs_n, .io_in);

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic fin(input string s);
      $display("test %s done", s);
   endtask : fin

   task automatic clear_err();
      err_clr <= 1'b1;
      @(posedge sys_clk);
      err_clr <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : clear_err

   // optional unlock, then one command; waits for idle under a bound
   task automatic cmd(input logic [7:0] op, input logic ql, input logic al, input int ab,
                      input logic [31:0] a, input int nb, input int extra, input logic ul);
      int n;
      four_lane_cmd_mode <= ql;
      addr_len_sel <= al;
      @(posedge sys_clk);
      if (ul) begin
         host_u.frame(flash_cmd_pkg::OP_WRITE_UNLOCK_CMD, ql ? 4 : 1, 32'h0, 0, 0, 0);
      end
      b_chk = n_chk;
      b_go = n_go;
      b_busy = n_busy;
      host_u.frame(op, ql ? 4 : 1, a, ab, nb, extra);
      n = 0;
      while (op_in_progress !== 1'b0 && n < 20000) begin
         @(posedge sys_clk);
         n++;
      end
      // A busy flag that never drops is a failure, not a silent pass
      if (n == 20000) begin
         err_total++;
         $display("MISMATCH t=%0t busy never dropped", $time);
         test_done();
      end
   endtask : cmd

   // Snapshots of check requests, pulse and busy counts, drained words, hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (chk_req === 1'b1) begin
         n_chk <= n_chk + 1;
         cap_kind <= array_kind;
         cap_addr <= array_addr;
         cap_len <= array_len;
      end
      if (array_go === 1'b1) n_go <= n_go + 1;
      if (op_in_progress === 1'b1) n_busy <= n_busy + 1;
      if (prog_valid === 1'b1 && prog_ready === 1'b1) words.push_back(prog_data);
      if (cyc == 60000) begin
         err_total++;
         $display("MISMATCH t=%0t timeout", $time);
         test_done();
      end
   end

   initial begin
      {cyc, n_chk, n_go, n_busy, err_total, total_checks} = '0;
      {quad_en, four_lane_cmd_mode, addr_len_sel, chk_prot, err_clr} = '0;
      prog_ready = 1'b1;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk(write_latch, 0, "latch after reset");
      chk(op_in_progress, 0, "busy after reset");
      fin("reset");
      for (int r = 0; r < 12; r++) begin
         chk_prot <= rows[r].prot;
         cmd(rows[r].op, rows[r].ql, rows[r].al, rows[r].ab, rows[r].a, 0, 0, 1'b1);
         chk(cap_kind, rows[r].kind, "kind");
         chk(cap_addr, rows[r].ea, "target");
         chk(n_go - b_go, !rows[r].prot, "start");
         chk(erase_err, rows[r].prot, "erase error");
         chk(n_busy - b_busy, rows[r].prot ? 0 : 1 + ((rows[r].kind ==
             flash_cmd_pkg::K_ARRAY) ? CHIP_N : ERASE_N), "busy");
         chk(write_latch, 0, "latch");
         clear_err();
         fin("table row");
      end
      chk_prot <= 1'b0;
      cmd(8'h20, 0, 0, 24, 32'h0, 0, 0, 1'b0);
      chk(n_chk - b_chk, 0, "no latch");
      cmd(8'h20, 0, 0, 24, 32'h0, 0, 1, 1'b1);
      chk(n_chk - b_chk, 0, "late select");
      chk(write_latch, 1, "latch kept");
      cmd(8'h60, 1, 0, 0, 32'h0, 0, 8, 1'b0);
      chk(n_chk - b_chk, 0, "array late select");
      cmd(8'h32, 0, 0, 24, 32'h100, 1, 0, 1'b0);
      chk(n_chk - b_chk, 0, "no quad");
      quad_en <= 1'b1;
      cmd(8'h32, 0, 0, 24, 32'h100, 1, 1, 1'b0);
      chk(n_go - b_go, 0, "half byte");
      fin("refusals");
      words.delete();
      cmd(8'h34, 1, 0, 32, 32'h12345600, 9, 0, 1'b1);
      chk(cap_kind, flash_cmd_pkg::K_LOAD, "load kind");
      chk(cap_addr, 32'h12345600, "load addr");
      chk(cap_len, 9'h009, "load len");
      chk(words.size(), 2, "word count");
      chk(words[1], 64'hffffffffffffff08, "padded word");
      chk(write_latch, 0, "latch after load");
      fin("short load");
      words.delete();
      prog_ready <= 1'b0;
      fork
         cmd(8'h32, 0, 1, 32, 32'h00000200, 260, 0, 1'b1);
         begin
            repeat (5000) @(posedge sys_clk);
            prog_ready <= 1'b1;
         end
      join
      chk(cap_len, 9'h100, "page len");
      chk(words.size(), 32, "page words");
      chk(words[0], 64'h0706050403020100, "first word");
      chk(words[31], 64'hfffefdfcfbfaf9f8, "last word");
      chk(n_busy - b_busy > 300, 1, "busy over drain");
      fin("full page");
      chk_prot <= 1'b1;
      cmd(8'h32, 1, 0, 24, 32'h0, 1, 0, 1'b1);
      chk(prog_err, 1, "program error");
      chk(n_go - b_go, 0, "no load start");
      clear_err();
      chk(prog_err, 0, "error cleared");
      fin("protected load");
      chk_prot <= 1'b0;
      host_u.frame(flash_cmd_pkg::OP_WRITE_UNLOCK_CMD, 4, 32'h0, 0, 0, 0);
      host_u.frame(8'hc7, 4, 32'h0, 0, 0, 0);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk(op_in_progress, 0, "busy in reset");
      chk(write_latch, 0, "latch in reset");
      rst <= 1'b0;
      fin("mid-run reset");
      // Link must work again at once: fresh unlock, then an array wipe
      cmd(8'h60, 1, 0, 0, 32'h0, 0, 0, 1'b1);
      chk(n_go - b_go, 1, "start after reset");
      chk(n_busy - b_busy, 1 + CHIP_N, "busy after reset run");
      chk(write_latch, 0, "latch after recovery");
      fin("recovery");
      test_done();
   end
endmodule : flash_quad_program_and_erase_cmds_tb
`default_nettype wire
